// >>> design/slow_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none

module slow_tick_gen
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic use_xtal,
    input  wire logic xtal_clk_pin,
    output logic      tick_q
);

    logic                        xs1_q;
    logic                        xs2_q;
    logic                        xs3_q;
    logic [twu_pkg::DIV_W-1:0]   div_q;
    logic [twu_pkg::DIV_W-1:0]   div_d;
    logic                        tick_d;

    always_comb
    begin
        // wrap of the divider keeps ticks at or below the maximum
        div_d  = (div_q == twu_pkg::DIV_LAST) ? '0 : div_q + 1'b1;
        // crystal rising edge or fast-clock prescaler wrap
        tick_d = use_xtal ? (xs2_q & ~xs3_q) : (div_q == twu_pkg::DIV_LAST);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            xs1_q  <= 1'b0;
            xs2_q  <= 1'b0;
            xs3_q  <= 1'b0;
            div_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            xs1_q  <= xtal_clk_pin;
            xs2_q  <= xs1_q;
            xs3_q  <= xs2_q;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    // prescaler path never yields ticks on two ref_clk cycles in a row
    chk_tick_spacing: assert property
        (@(posedge ref_clk) disable iff (reset)
         (tick_q && !use_xtal) |=> !tick_q)
        else $error("slow ticks too close together");

endmodule // slow_tick_gen

`default_nettype wire

// >>> design/timing_watchdog_unit.sv
// Notes on behaviour
// - slow counting logic runs at most 100 kHz
// - slow tick from crystal or fast-clock prescaler
// - down counter, per tick or prescale underflow
// - fast-side writes synchronised before taking effect
// - write delay varies with clock phase, ratio
// - active mode: effect within four counter periods
// - power save: effect within eight counter periods
`timescale 1ns/100ps
`default_nettype none

module timing_watchdog_unit
(
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          use_xtal,
    input  wire logic          xtal_clk_pin,
    input  wire logic          power_save,
    input  wire logic          cfg_wr,
    input  wire twu_pkg::cfg_s cfg_data,
    input  wire logic          service_wr,
    input  wire logic [7:0]    service_data,
    input  wire logic          error_clear,
    output logic [7:0]         watchdog_count_value_q,
    output logic               watchdog_error_q,
    output logic               sync_busy_q
);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic          slow_clock_tick;
    twu_pkg::cfg_s cfg_q;
    twu_pkg::cfg_s cfg_d;
    twu_pkg::cfg_s cfg_pend_q;
    twu_pkg::cfg_s cfg_pend_d;
    logic          cfg_busy_q;
    logic          cfg_busy_d;
    logic [3:0]    cfg_cnt_q;
    logic [3:0]    cfg_cnt_d;
    logic [7:0]    svc_data_q;
    logic [7:0]    svc_data_d;
    logic          svc_busy_q;
    logic          svc_busy_d;
    logic [3:0]    svc_cnt_q;
    logic [3:0]    svc_cnt_d;
    logic          svc_apply;
    logic          cfg_apply;
    logic [3:0]    sync_len;
    logic [7:0]    pre_q;
    logic [7:0]    pre_d;
    logic [7:0]    wd_d;
    logic          err_d;
    logic          busy_d;
    logic          prescale_timer_underflow;
    logic          count_tick;
    logic          svc_bad;

    slow_tick_gen u_tick
    (
        .ref_clk      (ref_clk),
        .reset        (reset),
        .use_xtal     (use_xtal),
        .xtal_clk_pin (xtal_clk_pin),
        .tick_q       (slow_clock_tick)
    );

    // write synchronisation into the slow-tick logic
    always_comb
    begin
        // two ticks keep four counter periods; four keep eight
        sync_len   = power_save ? twu_pkg::SYNC_SAVE : twu_pkg::SYNC_ACTIVE;
        cfg_apply  = cfg_busy_q && slow_clock_tick
                     && (cfg_cnt_q + 4'h1 >= sync_len);
        svc_apply  = svc_busy_q && slow_clock_tick
                     && (svc_cnt_q + 4'h1 >= sync_len);
        cfg_pend_d = cfg_pend_q;
        cfg_busy_d = cfg_busy_q;
        cfg_cnt_d  = cfg_cnt_q;
        svc_data_d = svc_data_q;
        svc_busy_d = svc_busy_q;
        svc_cnt_d  = svc_cnt_q;
        cfg_d      = cfg_q;
        // delay counts whole slow ticks from whatever phase the write hit
        if (cfg_apply)
        begin
            cfg_d      = cfg_pend_q;
            cfg_busy_d = 1'b0;
        end
        else if (cfg_busy_q && slow_clock_tick)
        begin
            cfg_cnt_d = cfg_cnt_q + 4'h1;
        end
        if (svc_apply)
        begin
            svc_busy_d = 1'b0;
        end
        else if (svc_busy_q && slow_clock_tick)
        begin
            svc_cnt_d = svc_cnt_q + 4'h1;
        end
        // a fresh write restarts its own synchronisation
        if (cfg_wr)
        begin
            cfg_pend_d = cfg_data;
            cfg_busy_d = 1'b1;
            cfg_cnt_d  = 4'h0;
        end
        if (service_wr)
        begin
            svc_data_d = service_data;
            svc_busy_d = 1'b1;
            svc_cnt_d  = 4'h0;
        end
        busy_d = cfg_busy_d | svc_busy_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cfg_q       <= twu_pkg::CFG_RESET;
            cfg_pend_q  <= twu_pkg::CFG_RESET;
            cfg_busy_q  <= 1'b0;
            cfg_cnt_q   <= 4'h0;
            svc_data_q  <= 8'h00;
            svc_busy_q  <= 1'b0;
            svc_cnt_q   <= 4'h0;
            sync_busy_q <= 1'b0;
        end
        else
        begin
            cfg_q       <= cfg_d;
            cfg_pend_q  <= cfg_pend_d;
            cfg_busy_q  <= cfg_busy_d;
            cfg_cnt_q   <= cfg_cnt_d;
            svc_data_q  <= svc_data_d;
            svc_busy_q  <= svc_busy_d;
            svc_cnt_q   <= svc_cnt_d;
            sync_busy_q <= busy_d;
        end
    end

    // prescale timer and watchdog down counter
    always_comb
    begin
        prescale_timer_underflow = slow_clock_tick && (pre_q == 8'h00);
        pre_d = pre_q;
        if (slow_clock_tick)
        begin
            pre_d = (pre_q == 8'h00) ? cfg_q.prescale_reload
                                     : pre_q - 8'h01;
        end
        count_tick = cfg_q.tick_on_prescale ? prescale_timer_underflow
                                            : slow_clock_tick;
        // early service means the count is still above the window top
        svc_bad = (svc_data_q != twu_pkg::SERVICE_KEY)
                  || (watchdog_count_value_q > cfg_q.window_top);
        wd_d  = watchdog_count_value_q;
        err_d = watchdog_error_q;
        if (error_clear)
        begin
            err_d = 1'b0;
        end
        if (svc_apply)
        begin
            wd_d = cfg_q.wd_reload;
            if (svc_bad)
            begin
                err_d = 1'b1;
            end
        end
        else if (count_tick)
        begin
            if (watchdog_count_value_q == 8'h00)
            begin
                wd_d  = cfg_q.wd_reload;
                err_d = 1'b1;
            end
            else
            begin
                wd_d = watchdog_count_value_q - 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pre_q                  <= twu_pkg::PRE_RESET;
            watchdog_count_value_q <= twu_pkg::WD_RESET;
            watchdog_error_q       <= 1'b0;
        end
        else
        begin
            pre_q                  <= pre_d;
            watchdog_count_value_q <= wd_d;
            watchdog_error_q       <= err_d;
        end
    end

    // helper: counter periods spent waiting by the service write
    logic [3:0] wait_periods_q;
    always_ff @(posedge ref_clk)
    begin
        if (reset || service_wr || !svc_busy_q)
        begin
            wait_periods_q <= 4'h0;
        end
        else if (count_tick && wait_periods_q != 4'hF)
        begin
            wait_periods_q <= wait_periods_q + 4'h1;
        end
    end

    chk_active_delay: assert property
        (!power_save |-> wait_periods_q <= twu_pkg::LIMIT_ACTIVE)
        else $error("active-mode write took too long");

    chk_save_delay: assert property
        (power_save |-> wait_periods_q <= twu_pkg::LIMIT_SAVE)
        else $error("power-save write took too long");

    chk_cfg_lands: assert property
        (cfg_apply && !cfg_wr |=> cfg_q == $past(cfg_pend_q))
        else $error("config write did not land");

    chk_no_early_cfg: assert property
        (cfg_wr && !slow_clock_tick |=> !cfg_apply)
        else $error("config applied without slow tick");

    chk_count_down: assert property
        (count_tick && !svc_apply && watchdog_count_value_q != 8'h00
         |=> watchdog_count_value_q == $past(watchdog_count_value_q) - 8'h01)
        else $error("watchdog did not decrement");

    chk_expiry_err: assert property
        (count_tick && !svc_apply && watchdog_count_value_q == 8'h00
         |=> watchdog_error_q)
        else $error("expiry not flagged");

    chk_early_err: assert property
        (svc_apply && svc_bad |=> watchdog_error_q)
        else $error("bad service not flagged");

    chk_good_svc: assert property
        (svc_apply && !svc_bad && !watchdog_error_q
         |=> !watchdog_error_q
             && watchdog_count_value_q == $past(cfg_q.wd_reload))
        else $error("good service mishandled");

    chk_busy_out: assert property
        (service_wr |=> sync_busy_q)
        else $error("busy not shown after write");

    cov_good_service: cover property (@(posedge ref_clk) disable iff (reset)
        svc_apply && !svc_bad);
    cov_early_service: cover property (@(posedge ref_clk) disable iff (reset)
        svc_apply && svc_bad);
    cov_expiry: cover property (@(posedge ref_clk) disable iff (reset)
        count_tick && watchdog_count_value_q == 8'h00);
    cov_save_apply: cover property (@(posedge ref_clk) disable iff (reset)
        power_save && cfg_apply);

endmodule // timing_watchdog_unit

`default_nettype wire

// >>> include/twu_pkg.sv
`default_nettype none

package twu_pkg;

    // fast clock and the highest slow rate the counting logic supports
    localparam int unsigned REF_CLK_KHZ  = 25000;
    localparam int unsigned SLOW_MAX_KHZ = 100;
    // divider rounds up so the derived slow rate never exceeds the maximum
    localparam int unsigned SLOW_DIV     =
        (REF_CLK_KHZ + SLOW_MAX_KHZ - 1) / SLOW_MAX_KHZ;
    localparam int unsigned DIV_W        = 8;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

    // slow ticks a write waits before it takes effect
    localparam logic [3:0] SYNC_ACTIVE   = 4'h2;
    localparam logic [3:0] SYNC_SAVE     = 4'h4;
    // counter clock periods a write may take at most
    localparam logic [3:0] LIMIT_ACTIVE  = 4'h4;
    localparam logic [3:0] LIMIT_SAVE    = 4'h8;

    localparam logic [7:0] SERVICE_KEY   = 8'hA5;

    typedef struct packed {
        logic       tick_on_prescale;
        logic [7:0] prescale_reload;
        logic [7:0] wd_reload;
        logic [7:0] window_top;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{
        tick_on_prescale: 1'b0,
        prescale_reload:  8'h0F,
        wd_reload:        8'hFF,
        window_top:       8'h40
    };

    localparam logic [7:0] WD_RESET  = 8'hFF;
    localparam logic [7:0] PRE_RESET = 8'h0F;

endpackage

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic          ref_clk      = 1'b0;
    logic          reset        = 1'b1;
    logic          use_xtal     = 1'b0;
    logic          xtal_clk_pin = 1'b0;
    logic          power_save   = 1'b0;
    logic          cfg_wr       = 1'b0;
    twu_pkg::cfg_s cfg_data     = twu_pkg::CFG_RESET;
    logic          service_wr   = 1'b0;
    logic [7:0]    service_data = 8'h00;
    logic          error_clear  = 1'b0;
    logic [7:0]    count;
    logic          err;
    logic          busy;
    int            error_cnt    = 0;
    int            n_compared   = 0;

    always #20 ref_clk = ~ref_clk;
    // crystal near 32 kHz, unrelated in phase to ref_clk
    always #15625 xtal_clk_pin = ~xtal_clk_pin;

    timing_watchdog_unit i_timing_watchdog_unit
    (
        .ref_clk                (ref_clk),
        .reset                  (reset),
        .use_xtal               (use_xtal),
        .xtal_clk_pin           (xtal_clk_pin),
        .power_save             (power_save),
        .cfg_wr                 (cfg_wr),
        .cfg_data               (cfg_data),
        .service_wr             (service_wr),
        .service_data           (service_data),
        .error_clear            (error_clear),
        .watchdog_count_value_q (count),
        .watchdog_error_q       (err),
        .sync_busy_q            (busy)
    );

    task automatic report_and_stop;
        if (error_cnt == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic fail(input string m);
        $display("MISMATCH at %0t: %s", $time, m);
        error_cnt++;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                        input string m);
        n_compared++;
        if (got !== exp)
            fail(m);
    endtask

    task automatic chk1(input logic got, input logic exp, input string m);
        n_compared++;
        if (got !== exp)
            fail(m);
    endtask

    task automatic chk_rng(input int n, input int lo, input int hi,
                           input string m);
        n_compared++;
        if (n < lo || n > hi)
            fail(m);
    endtask

    task automatic write_cfg(input logic t, input logic [7:0] p,
                             input logic [7:0] w, input logic [7:0] top);
        @(posedge ref_clk);
        cfg_wr   <= 1'b1;
        cfg_data <= {t, p, w, top};
        @(posedge ref_clk);
        cfg_wr   <= 1'b0;
    endtask

    task automatic write_svc(input logic [7:0] d);
        @(posedge ref_clk);
        service_wr   <= 1'b1;
        service_data <= d;
        @(posedge ref_clk);
        service_wr   <= 1'b0;
    endtask

    // edges from capture until the pending write has landed
    task automatic wait_idle(input int lim, output int n);
        n = 0;
        #1;
        chk1(busy, 1'b1, "busy not raised by write");
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (busy !== 1'b0 && n < lim);
        if (busy !== 1'b0)
        begin
            fail("write never applied");
            report_and_stop();
        end
    endtask

    task automatic wait_change(input int lim, output int n);
        logic [7:0] v;
        v = count;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (count === v && n < lim);
        if (count === v)
        begin
            fail("count stalled");
            report_and_stop();
        end
    endtask

    task automatic clear_err;
        @(posedge ref_clk);
        error_clear <= 1'b1;
        @(posedge ref_clk);
        error_clear <= 1'b0;
        #1;
        chk1(err, 1'b0, "error not cleared");
    endtask

    task automatic s_divider_count;
        int n;
        chk8(count, 8'hFF, "count reset");
        chk1(err, 1'b0, "error reset");
        wait_change(300, n);
        chk8(count, 8'hFE, "first decrement");
        wait_change(300, n);
        chk8(count, 8'hFD, "second decrement");
        chk_rng(n, 250, 250, "divider slow tick period");
    endtask

    task automatic s_early_service;
        int n;
        write_svc(twu_pkg::SERVICE_KEY);
        wait_idle(1100, n);
        chk_rng(n, 1, 1001, "active sync too slow");
        chk1(err, 1'b1, "early service not flagged");
        chk8(count, 8'hFF, "service reload");
        clear_err();
    endtask

    task automatic s_valid_and_expiry;
        int n;
        write_cfg(1'b0, 8'h0F, 8'h04, 8'hFF);
        wait_idle(1100, n);
        chk_rng(n, 1, 1001, "cfg sync too slow");
        write_svc(8'h5A);
        write_svc(twu_pkg::SERVICE_KEY);
        wait_idle(1100, n);
        chk1(err, 1'b0, "replaced service flagged");
        chk8(count, 8'h04, "valid service reload");
        for (int i = 3; i >= 0; i--)
        begin
            wait_change(300, n);
            chk8(count, 8'(i), "countdown to zero");
            chk1(err, 1'b0, "early expiry");
        end
        wait_change(300, n);
        chk1(err, 1'b1, "expiry not flagged");
        chk8(count, 8'h04, "reload after expiry");
        clear_err();
        write_svc(8'h5A);
        wait_idle(1100, n);
        chk1(err, 1'b1, "wrong key accepted");
        clear_err();
    endtask

    task automatic s_power_save;
        int n;
        @(posedge ref_clk);
        power_save <= 1'b1;
        write_cfg(1'b0, 8'h0F, 8'h20, 8'hFF);
        // service one tick behind the config: the old reload of 4 would
        // expire during a service sync started after the config landed
        wait_change(300, n);
        chk8(count, 8'h03, "power save tick");
        write_svc(twu_pkg::SERVICE_KEY);
        wait_idle(2100, n);
        chk_rng(n, 1, 2001, "power save sync too slow");
        chk8(count, 8'h20, "power save service reload");
        chk1(err, 1'b0, "power save service flagged");
        @(posedge ref_clk);
        power_save <= 1'b0;
    endtask

    task automatic s_prescale;
        int n;
        write_cfg(1'b1, 8'h03, 8'h20, 8'hFF);
        wait_idle(1100, n);
        write_svc(twu_pkg::SERVICE_KEY);
        wait_idle(1100, n);
        // prescaler first runs down its old reload of 16 ticks
        wait_change(4100, n);
        wait_change(1100, n);
        chk_rng(n, 750, 1000, "prescaled decrement period");
        chk8(count, 8'h1E, "prescaled count");
    endtask

    task automatic s_xtal;
        int n;
        write_cfg(1'b0, 8'h0F, 8'h20, 8'hFF);
        wait_idle(1100, n);
        @(posedge ref_clk);
        use_xtal <= 1'b1;
        write_svc(twu_pkg::SERVICE_KEY);
        wait_idle(2000, n);
        wait_change(1000, n);
        wait_change(1000, n);
        // one crystal period is about 781 fast cycles
        chk_rng(n, 770, 794, "crystal tick period");
    endtask

    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        s_divider_count();
        s_early_service();
        s_valid_and_expiry();
        s_power_save();
        s_prescale();
        s_xtal();
        report_and_stop();
    end
endmodule // tb

`default_nettype wire
